/* File: rtl/fcs_issue.sv */
// Two-pipe dispatcher for the FP issue queue
`timescale 1ns/1ps
module fcs_issue
  import fcs_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Offered instructions, slot 0 oldest
  input wire fcs_slot_s i_slot0,
  input wire fcs_slot_s i_slot1,
  // Taken this cycle
  output logic o_take0,
  output logic o_take1,
  // Dispatch to pipes
  output logic o_a_valid,
  output logic [7:0] o_a_tag,
  output logic o_b_valid,
  output logic [7:0] o_b_tag
);
  logic s0_to_b;
  logic s1_go;

  // Old slot goes to pipe b only when the young one cannot
  assign s0_to_b = i_slot0.b_ok && i_slot1.valid && !i_slot1.b_ok;
  assign s1_go = i_slot0.valid && i_slot1.valid && (s0_to_b || i_slot1.b_ok);
  assign o_take0 = i_slot0.valid;
  assign o_take1 = s1_go;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_a_valid <= 1'b0;
      o_a_tag <= 8'h00;
      o_b_valid <= 1'b0;
      o_b_tag <= 8'h00;
    end else begin
      // One per pipe per cycle
      o_a_valid <= (i_slot0.valid && !s0_to_b) || (s1_go && s0_to_b);
      o_b_valid <= (i_slot0.valid && s0_to_b) || (s1_go && !s0_to_b);
      o_a_tag <= s0_to_b ? i_slot1.tag : i_slot0.tag;
      o_b_tag <= s0_to_b ? i_slot0.tag : i_slot1.tag;
    end
  end
endmodule // fcs_issue

/* File: rtl/fcs_map.sv */
// Logical to physical FP register map table
`timescale 1ns/1ps
module fcs_map
  import fcs_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Remap write
  input wire logic i_wr,
  input wire logic [4:0] i_wr_idx,
  input wire logic [5:0] i_wr_phys,
  // Lookup
  input wire logic [4:0] i_rd_idx,
  output logic [5:0] o_rd_phys
);
  logic [5:0] ent_q [FCS_LOG_REGS];

  // Identity map after reset keeps early code usable
  for (genvar g = 0; g < FCS_LOG_REGS; g++) begin : g_ent
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        ent_q[g] <= 6'(g);
      end else if (i_wr && i_wr_idx == 5'(g)) begin
        ent_q[g] <= i_wr_phys;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_phys <= 6'h00;
    end else begin
      o_rd_phys <= ent_q[i_rd_idx];
    end
  end
endmodule // fcs_map

/* File: rtl/fcs_pkg.sv */
// Shared constants and carriers for the FP control/status block
package fcs_pkg;
  // Control register indices
  localparam logic [4:0] FCS_IDX_IMPL_REV = 5'h00;
  localparam logic [4:0] FCS_IDX_CTL_STATUS = 5'h1f;
  // Identity fields, values arbitrary
  localparam logic [7:0] FCS_IMPL_CODE = 8'h3c;
  localparam logic [7:0] FCS_REV_CODE = 8'h02;
  localparam int FCS_IMPL_LSB = 8;
  localparam int FCS_REV_LSB = 0;
  // Control/status field positions
  localparam int FCS_CC_HI_MSB = 31;
  localparam int FCS_CC_HI_LSB = 25;
  localparam int FCS_FS_BIT = 24;
  localparam int FCS_CC0_BIT = 23;
  localparam int FCS_CC1_BIT = 25;
  localparam int FCS_CAUSE_MSB = 17;
  localparam int FCS_CAUSE_LSB = 12;
  localparam int FCS_EN_MSB = 11;
  localparam int FCS_EN_LSB = 7;
  localparam int FCS_FLAG_MSB = 6;
  localparam int FCS_FLAG_LSB = 2;
  localparam int FCS_RM_MSB = 1;
  localparam int FCS_RM_LSB = 0;
  localparam int FCS_UNIMP_BIT = 5;
  localparam logic [31:0] FCS_CSR_WMASK = 32'hff83_ffff;
  localparam logic [31:0] FCS_CSR_RESET = 32'h0000_0000;
  // Status word width-mode bit position
  localparam int FCS_WIDE_MODE_BIT = 26;
  // Cause-register code reported for an FP exception, arbitrary
  localparam logic [4:0] FCS_EXC_CODE = 5'h0f;
  // Register file geometry
  localparam int FCS_LOG_REGS = 32;
  localparam int FCS_LOG_W = 5;
  localparam int FCS_PHYS_W = 6;
  localparam int FCS_TAG_W = 8;

  typedef enum logic [1:0] {
    FCS_RND_NEAREST_EVEN = 2'h0,
    FCS_RND_TOWARD_ZERO = 2'h1,
    FCS_RND_UP_POSITIVE = 2'h2,
    FCS_RND_DOWN_NEGATIVE = 2'h3
  } fcs_round_e;

  // Completion report from a pipe
  typedef struct packed {
    logic done;
    logic arith;
    logic [5:0] cause;
    logic cmp;
    logic paired;
    logic res_lo;
    logic res_hi;
  } fcs_op_s;

  // Control-move request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] idx;
    logic [31:0] wdata;
  } fcs_ctl_s;

  // Instruction offered by the queue
  typedef struct packed {
    logic valid;
    logic b_ok;
    logic [7:0] tag;
  } fcs_slot_s;
endpackage

/* File: rtl/fcs_top.sv */
// FP coprocessor control, status, rename and issue
`timescale 1ns/1ps
module fcs_top
  import fcs_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Control moves
  input wire fcs_ctl_s i_ctl,
  output logic o_ctl_rvalid,
  output logic [31:0] o_ctl_rdata,
  // Processor status bit for register width
  input wire logic i_wide_register_mode,
  // Completing operations
  input wire fcs_op_s i_op,
  // Issue queue
  input wire fcs_slot_s i_slot0,
  input wire fcs_slot_s i_slot1,
  output logic o_take0,
  output logic o_take1,
  output logic o_fp_pipe_a_valid,
  output logic [7:0] o_fp_pipe_a_tag,
  output logic o_fp_pipe_b_valid,
  output logic [7:0] o_fp_pipe_b_tag,
  // Rename
  input wire logic i_map_wr,
  input wire logic [4:0] i_map_idx,
  input wire logic [5:0] i_map_phys,
  input wire logic [4:0] i_lookup_idx,
  output logic [5:0] o_phys_addr,
  output logic o_phys_hi_half,
  // Control to the pipes
  output logic [1:0] o_rounding_select,
  output logic o_flush_denormal,
  output logic o_dest_wr_en,
  output logic o_compare_result_bit,
  // Exception to the core
  output logic o_fp_exception,
  output logic [4:0] o_float_exception_code
);
  logic [31:0] csr_q;
  logic [31:0] csr_d;
  logic hi_half_q;
  logic take0;
  logic take1;
  logic [5:0] map_phys;
  logic [4:0] look_idx;
  logic op_exc;
  logic [5:0] trig;
  logic exc_d;

  // Decoded fields
  logic [5:0] cause;
  logic [4:0] enables;
  logic [4:0] flags;
  assign cause = csr_q[FCS_CAUSE_MSB:FCS_CAUSE_LSB];
  assign enables = csr_q[FCS_EN_MSB:FCS_EN_LSB];
  assign flags = csr_q[FCS_FLAG_MSB:FCS_FLAG_LSB];

  fcs_issue u_issue (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_slot0(i_slot0),
    .i_slot1(i_slot1),
    .o_take0(take0),
    .o_take1(take1),
    .o_a_valid(o_fp_pipe_a_valid),
    .o_a_tag(o_fp_pipe_a_tag),
    .o_b_valid(o_fp_pipe_b_valid),
    .o_b_tag(o_fp_pipe_b_tag)
  );

  // Narrow mode folds odd names onto the even register
  assign look_idx = i_wide_register_mode ? i_lookup_idx
                  : {i_lookup_idx[4:1], 1'b0};

  fcs_map u_map (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_wr(i_map_wr),
    .i_wr_idx(i_map_idx),
    .i_wr_phys(i_map_phys),
    .i_rd_idx(look_idx),
    .o_rd_phys(map_phys)
  );
  assign o_phys_addr = map_phys;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_half_q <= 1'b0;
    end else begin
      hi_half_q <= !i_wide_register_mode && i_lookup_idx[0];
    end
  end
  assign o_phys_hi_half = hi_half_q;

  // Issue handshake is registered, one cycle after the queue's offer
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_take0 <= 1'b0;
      o_take1 <= 1'b0;
    end else begin
      o_take0 <= take0;
      o_take1 <= take1;
    end
  end

  // Operation outcome: enabled cause or unimplemented traps
  assign trig = {i_op.cause[FCS_UNIMP_BIT], i_op.cause[4:0] & enables};
  assign op_exc = i_op.done && i_op.arith && (|trig);

  always_comb begin
    csr_d = csr_q;
    if (i_op.done && i_op.arith) begin
      csr_d[FCS_CAUSE_MSB:FCS_CAUSE_LSB] = i_op.cause;
      if (!op_exc) begin
        csr_d[FCS_FLAG_MSB:FCS_FLAG_LSB] = flags | i_op.cause[4:0];
      end
    end
    if (i_op.done && i_op.cmp && !op_exc) begin
      csr_d[FCS_CC0_BIT] = i_op.res_lo;
      if (i_op.paired) begin
        csr_d[FCS_CC1_BIT] = i_op.res_hi;
      end
    end
    // Control write comes later in program order, so it wins
    if (i_ctl.wr && i_ctl.idx == FCS_IDX_CTL_STATUS) begin
      csr_d = i_ctl.wdata & FCS_CSR_WMASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      csr_q <= FCS_CSR_RESET;
    end else begin
      csr_q <= csr_d;
    end
  end

  // Level from the stored state; stays until a status write or the next arithmetic op leaves no trapping cause
  assign exc_d = csr_d[FCS_CAUSE_MSB]
    | (|(csr_d[FCS_CAUSE_LSB+4:FCS_CAUSE_LSB]
         & csr_d[FCS_EN_MSB:FCS_EN_LSB]));

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fp_exception <= 1'b0;
      o_float_exception_code <= 5'h00;
    end else begin
      o_fp_exception <= exc_d;
      o_float_exception_code <= exc_d ? FCS_EXC_CODE : 5'h00;
    end
  end

  // Destination write only when no trap is taken
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dest_wr_en <= 1'b0;
    end else begin
      o_dest_wr_en <= i_op.done && !op_exc;
    end
  end

  // Mode outputs follow the register
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rounding_select <= FCS_RND_NEAREST_EVEN;
      o_flush_denormal <= 1'b0;
      o_compare_result_bit <= 1'b0;
    end else begin
      o_rounding_select <= csr_d[FCS_RM_MSB:FCS_RM_LSB];
      o_flush_denormal <= csr_d[FCS_FS_BIT];
      o_compare_result_bit <= csr_d[FCS_CC0_BIT];
    end
  end

  // Control reads; unused indices read zero
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ctl_rvalid <= 1'b0;
      o_ctl_rdata <= 32'h0000_0000;
    end else begin
      o_ctl_rvalid <= i_ctl.rd;
      if (!i_ctl.rd) begin
        o_ctl_rdata <= 32'h0000_0000;
      end else if (i_ctl.idx == FCS_IDX_IMPL_REV) begin
        o_ctl_rdata <= {16'h0000, FCS_IMPL_CODE, FCS_REV_CODE};
      end else if (i_ctl.idx == FCS_IDX_CTL_STATUS) begin
        o_ctl_rdata <= csr_q;
      end else begin
        o_ctl_rdata <= 32'h0000_0000;
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence s_trap_op;
    i_op.done && i_op.arith && (|trig) && !i_ctl.wr;
  endsequence

  AST_ONE_PER_PIPE: assert property (
    (i_slot0.valid && i_slot1.valid && i_slot1.b_ok)
      |=> (o_fp_pipe_a_valid && o_fp_pipe_b_valid))
    else $error("dual issue lost");
  AST_IMPL_READ: assert property (
    (i_ctl.rd && i_ctl.idx == FCS_IDX_IMPL_REV)
      |=> (o_ctl_rdata[31:16] == 16'h0000
           && o_ctl_rdata[15:8] == FCS_IMPL_CODE && o_ctl_rvalid))
    else $error("identity read wrong");
  AST_NO_OTHER_CTL: assert property (
    (i_ctl.rd && i_ctl.idx != FCS_IDX_IMPL_REV
     && i_ctl.idx != FCS_IDX_CTL_STATUS) |=> o_ctl_rdata == 32'h0000_0000)
    else $error("unimplemented control reg not zero");
  AST_CAUSE_KEEP: assert property (
    (!(i_op.done && i_op.arith) && !i_ctl.wr) |=> $stable(cause))
    else $error("cause changed without operation");
  AST_TRAP_NO_WRITE: assert property (
    s_trap_op |=> (!o_dest_wr_en && o_fp_exception))
    else $error("trapped op wrote destination");
  AST_TRAP_FLAGS: assert property (
    s_trap_op |=> $stable(flags))
    else $error("flags moved on trap");
  AST_UNIMP_TRAP: assert property (
    (i_op.done && i_op.arith && i_op.cause[FCS_UNIMP_BIT] && !i_ctl.wr)
      |=> o_fp_exception && o_float_exception_code == FCS_EXC_CODE)
    else $error("unimplemented op did not trap");
  AST_FLAG_STICKY: assert property (
    !i_ctl.wr |=> ((flags & $past(flags)) == $past(flags)))
    else $error("flag cleared by operation");
  AST_CC0_ONLY: assert property (
    (!(i_op.done && i_op.cmp) && !i_ctl.wr) |=> $stable(csr_q[FCS_CC0_BIT]))
    else $error("cc0 changed by non-compare");
  AST_NARROW_HALF: assert property (
    (!i_wide_register_mode && i_lookup_idx[0]) |=> o_phys_hi_half)
    else $error("odd narrow name not upper half");

  // Paired compare lands both halves in one step
  sequence s_paired_cmp;
    i_op.done && i_op.cmp && i_op.paired && !op_exc && !i_ctl.wr;
  endsequence

  sequence s_both_cc_land;
    ##1 (csr_q[FCS_CC0_BIT] == $past(i_op.res_lo)
         && csr_q[FCS_CC1_BIT] == $past(i_op.res_hi));
  endsequence

  AST_PAIRED_CC1: assert property (
    s_paired_cmp |-> s_both_cc_land)
    else $error("paired compare bits wrong");
  AST_CTL_WRITE: assert property (
    (i_ctl.wr && i_ctl.idx == FCS_IDX_CTL_STATUS)
      |=> csr_q == ($past(i_ctl.wdata) & FCS_CSR_WMASK))
    else $error("status write lost");
  AST_WRITE_TRAP: assert property (
    (i_ctl.wr && i_ctl.idx == FCS_IDX_CTL_STATUS
     && (i_ctl.wdata[FCS_CAUSE_MSB]
         || |(i_ctl.wdata[FCS_CAUSE_LSB+4:FCS_CAUSE_LSB]
              & i_ctl.wdata[FCS_EN_MSB:FCS_EN_LSB]))) |=> o_fp_exception)
    else $error("enabled cause write did not trap");
  AST_DEST_CLEAN: assert property (
    (i_op.done && !op_exc) |=> o_dest_wr_en)
    else $error("clean op lost destination write");
  AST_MODE_FOLLOW: assert property (
    o_rounding_select == csr_q[FCS_RM_MSB:FCS_RM_LSB]
      && o_flush_denormal == csr_q[FCS_FS_BIT])
    else $error("mode outputs differ from register");
  AST_WIDE_FULL: assert property (
    i_wide_register_mode |=> !o_phys_hi_half)
    else $error("wide mode used half register");
  AST_EXC_CODE: assert property (
    o_fp_exception |-> o_float_exception_code == FCS_EXC_CODE)
    else $error("exception code missing");
  AST_RESERVED_ZERO: assert property (
    (csr_q & ~FCS_CSR_WMASK) == 32'h0000_0000)
    else $error("reserved status bits set");
endmodule // fcs_top

/* File: sim/fcs_core_model.sv */
// Behavioural CPU core issuing control moves and op reports
`timescale 1ns/1ps
module fcs_core_model
  import fcs_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Answers from the block
  input wire logic i_rvalid,
  input wire logic [31:0] i_rdata,
  // Requests to the block
  output fcs_ctl_s o_ctl,
  output fcs_op_s o_op
);
  initial begin
    o_ctl = '0;
    o_op = '0;
  end

  // Held for exactly one sampling edge, then released
  task automatic wr(input logic [4:0] idx, input logic [31:0] v);
    @(posedge i_mclk) o_ctl <= '{1'h1, 1'h0, idx, v};
    @(posedge i_mclk) o_ctl <= '0;
    #1;
  endtask

  task automatic rd(input logic [4:0] idx, output logic [31:0] d,
                    output logic v);
    @(posedge i_mclk) o_ctl <= '{1'h0, 1'h1, idx, 32'h0000_0000};
    @(posedge i_mclk) o_ctl <= '0;
    #1;
    v = i_rvalid;
    d = i_rdata;
  endtask

  task automatic op(input fcs_op_s o);
    @(posedge i_mclk) o_op <= o;
    @(posedge i_mclk) o_op <= '0;
    #1;
  endtask

  // Handler exit: causes cleared, everything else kept
  task automatic clr(input logic [31:0] csr);
    wr(5'h1f, csr & 32'hfffc_0fff);
  endtask
endmodule // fcs_core_model

/* File: sim/fcs_top_test.sv */
// Self-checking bench for the FP control/status block
`timescale 1ns/1ps
module fcs_top_test
  import fcs_pkg::*;
;
  // Op field packs {done, arith, cause[5:0], cmp, paired, lo, hi}
  typedef struct packed {
    logic [31:0] w;
    logic [11:0] op;
    logic [31:0] csr;
    logic exc;
    logic dest;
  } fcs_row_s;
  localparam fcs_row_s ROWS [7] = '{
    '{32'h0000_0000, 12'hc10, 32'h0000_1004, 1'h0, 1'h1},
    '{32'h0000_00c0, 12'hd00, 32'h0001_00c0, 1'h0, 1'h1},
    '{32'h0000_0080, 12'hc30, 32'h0000_3080, 1'h1, 1'h0},
    '{32'h0100_0003, 12'he00, 32'h0102_0003, 1'h1, 1'h0},
    '{32'h0000_0000, 12'h80a, 32'h0080_0000, 1'h0, 1'h1},
    '{32'h0080_0000, 12'h80d, 32'h0200_0000, 1'h0, 1'h1},
    '{32'h0000_5000, 12'h800, 32'h0000_5000, 1'h0, 1'h1}};
  logic i_mclk, i_rst_b, i_wide_register_mode, i_map_wr;
  logic [4:0] i_map_idx, i_lookup_idx;
  logic [5:0] i_map_phys, o_phys_addr;
  fcs_ctl_s i_ctl;
  fcs_op_s i_op;
  fcs_slot_s i_slot0, i_slot1;
  logic o_ctl_rvalid, o_take0, o_take1, o_fp_pipe_a_valid;
  logic o_fp_pipe_b_valid, o_phys_hi_half, o_flush_denormal;
  logic o_dest_wr_en, o_compare_result_bit, o_fp_exception;
  logic [31:0] o_ctl_rdata, d;
  logic [7:0] o_fp_pipe_a_tag, o_fp_pipe_b_tag;
  logic [1:0] o_rounding_select;
  logic [4:0] o_float_exception_code;
  logic v;
  int errors = 0;
  int tests_run = 0;
  logic [19:0] issue_seen;
  assign issue_seen = {o_fp_pipe_a_valid, o_fp_pipe_a_tag,
    o_fp_pipe_b_valid, o_fp_pipe_b_tag, o_take0, o_take1};

  fcs_top dut (.i_mclk, .i_rst_b, .i_ctl, .o_ctl_rvalid, .o_ctl_rdata,
    .i_wide_register_mode, .i_op, .i_slot0, .i_slot1, .o_take0,
    .o_take1, .o_fp_pipe_a_valid, .o_fp_pipe_a_tag, .o_fp_pipe_b_valid,
    .o_fp_pipe_b_tag, .i_map_wr, .i_map_idx, .i_map_phys, .i_lookup_idx,
    .o_phys_addr, .o_phys_hi_half, .o_rounding_select, .o_flush_denormal,
    .o_dest_wr_en, .o_compare_result_bit, .o_fp_exception,
    .o_float_exception_code);
  fcs_core_model core (.i_mclk, .i_rvalid(o_ctl_rvalid),
    .i_rdata(o_ctl_rdata), .o_ctl(i_ctl), .o_op(i_op));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic look(input logic [4:0] n, input logic [6:0] e);
    @(posedge i_mclk) i_lookup_idx <= n;
    @(posedge i_mclk) #1;
    chk({o_phys_addr, o_phys_hi_half}, e);
  endtask

  task automatic summarize();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    i_mclk = 1'h0;
    forever #5 i_mclk = ~i_mclk;
  end

  // Whole run is about a hundred cycles
  initial begin
    repeat (5000) @(posedge i_mclk);
    errors++;
    summarize();
  end

  initial begin
    {i_rst_b, i_wide_register_mode, i_map_wr, i_map_idx} = '0;
    {i_map_phys, i_lookup_idx, i_slot0, i_slot1} = '0;
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'h1;
    foreach (ROWS[k]) begin
      core.wr(5'h1f, ROWS[k].w);
      core.op(fcs_op_s'(ROWS[k].op));
      chk(o_dest_wr_en, ROWS[k].dest);
      chk(o_fp_exception, ROWS[k].exc);
      chk(o_compare_result_bit, ROWS[k].csr[23]);
      core.rd(5'h1f, d, v);
      chk(d, ROWS[k].csr);
      chk(o_fp_exception, ROWS[k].exc);
      if (ROWS[k].exc) begin
        chk(o_float_exception_code, FCS_EXC_CODE);
        core.clr(d);
        chk(o_fp_exception, 1'h0);
      end
    end
    // Identity register ignores writes; unused index reads zero
    core.wr(5'h00, 32'hffff_ffff);
    core.rd(5'h00, d, v);
    chk({v, d}, {1'h1, 16'h0000, FCS_IMPL_CODE, FCS_REV_CODE});
    core.rd(5'h05, d, v);
    chk(d, 32'h0000_0000);
    // All ones: reserved bits drop, enabled causes trap at once
    core.wr(5'h1f, 32'hffff_ffff);
    chk(o_fp_exception, 1'h1);
    core.rd(5'h1f, d, v);
    chk(d, FCS_CSR_WMASK);
    core.clr(d);
    chk({o_fp_exception, o_flush_denormal}, 2'h1);
    for (int k = 0; k < 4; k++) begin
      core.wr(5'h1f, 32'(k));
      chk({o_flush_denormal, o_rounding_select}, 3'(k));
    end
    // Two offers in one cycle, a lone offer, then a swapped pair
    @(posedge i_mclk) i_slot0 <= '{1'h1, 1'h0, 8'h11};
    i_slot1 <= '{1'h1, 1'h1, 8'h22};
    @(posedge i_mclk) i_slot0 <= '{1'h1, 1'h1, 8'h33};
    i_slot1 <= '0;
    #1;
    chk(issue_seen, 20'h8_8c8b);
    @(posedge i_mclk) i_slot0 <= '{1'h1, 1'h1, 8'h44};
    i_slot1 <= '{1'h1, 1'h0, 8'h55};
    #1;
    chk(issue_seen, 20'h9_9802);
    @(posedge i_mclk) i_slot0 <= '0;
    i_slot1 <= '0;
    #1;
    chk(issue_seen, 20'ha_ad13);
    look(5'h03, {6'h02, 1'h1});
    look(5'h02, {6'h02, 1'h0});
    @(posedge i_mclk) i_wide_register_mode <= 1'h1;
    look(5'h03, {6'h03, 1'h0});
    @(posedge i_mclk) i_map_wr <= 1'h1;
    i_map_idx <= 5'h07;
    i_map_phys <= 6'h2d;
    @(posedge i_mclk) i_map_wr <= 1'h0;
    look(5'h07, {6'h2d, 1'h0});
    // Mid-run reset: outputs drop at once, map and register restart
    @(posedge i_mclk) i_rst_b <= 1'h0;
    #1;
    chk({o_fp_exception, o_dest_wr_en, o_ctl_rvalid, o_take0}, 4'h0);
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'h1;
    core.rd(5'h1f, d, v);
    chk({v, d, o_rounding_select}, {1'h1, FCS_CSR_RESET, 2'h0});
    look(5'h07, {6'h07, 1'h0});
    summarize();
  end
endmodule // fcs_top_test
